// ==== pwm_ctl_map.vh ====
// Constants for the serial PCM input and PWM modulator control block
`ifndef PWM_CTL_MAP_VH
`define PWM_CTL_MAP_VH
// Serial framing kinds
`define FRAME_RJ 2'd0
`define FRAME_I2S 2'd1
`define FRAME_LJ 2'd2
`define FRAME_DSP 2'd3
// Format code table
`define FMT_RJ16 3'd0
`define FMT_RJ20 3'd1
`define FMT_RJ24 3'd2
`define FMT_I2S16 3'd3
`define FMT_I2S20 3'd4
`define FMT_I2S24 3'd5
`define FMT_LJ16 3'd6
`define FMT_DSP16 3'd7
// Master clock dividers: bit clock is mclk/4, frame clock is bit clock/64
`define BCLK_HALF_DIV 2'd1
`define BITS_PER_FRAME 6'd63
`define HALF_FRAME 6'd31
// Initialisation time after reset release or format change
`define INIT_TIME_US 10
`define INIT_CYCLES ((`INIT_TIME_US * 1000) / 10)
// Carrier phase counter width (PWM frame of 256 clocks)
`define PWM_BITS 8
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

// ==== sample_fifo.v ====
// Sample FIFO between the serial receiver and the modulator
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output reg [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always @* begin
    out_data_o = mem[rd_ptr[AW-1:0]];
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else if (clear_i) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sample_fifo

// ==== pwm_pair.v ====
// One channel of two differential PWM pairs with hard-mute
`timescale 1ns/1ps
`include "pwm_ctl_map.vh"
module pwm_pair (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire [`PWM_BITS-1:0] phase_i,
  input wire [`PWM_BITS-1:0] duty_i,
  output reg a_plus_o,
  output reg a_minus_o,
  output reg b_plus_o,
  output reg b_minus_o
);
  // Pair B runs on the inverted carrier so the two halves interleave
  wire a_on = phase_i < duty_i;
  wire b_on = (~phase_i) < duty_i;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_plus_o <= 1'b0;
      a_minus_o <= 1'b1;
      b_plus_o <= 1'b0;
      b_minus_o <= 1'b1;
    end else if (!run_i) begin
      a_plus_o <= 1'b0;
      a_minus_o <= 1'b1;
      b_plus_o <= 1'b0;
      b_minus_o <= 1'b1;
    end else begin
      a_plus_o <= a_on;
      a_minus_o <= ~a_on;
      b_plus_o <= b_on;
      b_minus_o <= ~b_on;
    end
  end
endmodule // pwm_pair

// ==== pcm_pwm_ctl.v ====
// Serial PCM input port and pin-level control of the PWM modulator
`timescale 1ns/1ps
`include "pwm_ctl_map.vh"
module pcm_pwm_ctl #(
  parameter INIT_CYCLES = `INIT_CYCLES
) (
  input wire CLK_I,
  input wire RST_I,
  input wire MASTER_SEL_I,
  input wire DOUBLE_SPEED_SEL_I,
  input wire DEEMPH_ENABLE_I,
  input wire DEEMPH_RATE_SEL_I,
  input wire MUTE_N_I,
  input wire POWER_DOWN_N_I,
  input wire FMT_SEL_0_I,
  input wire FMT_SEL_1_I,
  input wire FMT_SEL_2_I,
  input wire FACTORY_TEST_A_I,
  input wire FACTORY_TEST_B_I,
  input wire CRYSTAL_IN_I,
  output wire CRYSTAL_OUT_O,
  input wire BIT_CLK_I,
  output reg BIT_CLK_O,
  output wire BIT_CLK_OE_O,
  input wire FRAME_CLK_I,
  output reg FRAME_CLK_O,
  output wire FRAME_CLK_OE_O,
  input wire SERIAL_AUDIO_IN_I,
  output wire MCLK_OUT_O,
  output wire DEEMPH_ACTIVE_O,
  output wire DEEMPH_48K_O,
  output wire FMT_RESERVED_O,
  output wire LEFT_PAIR_A_PLUS_O,
  output wire LEFT_PAIR_A_MINUS_O,
  output wire LEFT_PAIR_B_PLUS_O,
  output wire LEFT_PAIR_B_MINUS_O,
  output wire RIGHT_PAIR_A_PLUS_O,
  output wire RIGHT_PAIR_A_MINUS_O,
  output wire RIGHT_PAIR_B_PLUS_O,
  output wire RIGHT_PAIR_B_MINUS_O,
  output reg VALID_L_O,
  output reg VALID_R_O
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_RESET = 3'b001;
  localparam [2:0] ST_INIT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Pins: 0 bit clk, 1 frame clk, 2 data, 3..5 format, 6 power-down
  wire [6:0] pin_raw = {POWER_DOWN_N_I, FMT_SEL_2_I, FMT_SEL_1_I, FMT_SEL_0_I,
                        SERIAL_AUDIO_IN_I, FRAME_CLK_I, BIT_CLK_I};
  reg [6:0] sync1;
  reg [6:0] sync2;
  reg [6:0] sync3;
  reg [6:0] pin_q;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
      always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          // A change counts once stages two and three agree
          if (sync2[gi] == sync3[gi]) begin
            pin_q[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate
  wire pdn_ok = pin_q[6];
  wire [2:0] fmt_code = pin_q[5:3];

  // ----------------------------------------
  // Format table
  // ----------------------------------------
  reg [1:0] frame_kind;
  reg [4:0] word_len;
  reg fmt_reserved;
  always @* begin
    frame_kind = `FRAME_RJ;
    word_len = 5'd16;
    fmt_reserved = 1'b0;
    case (fmt_code)
      `FMT_RJ16: begin word_len = 5'd16; end
      `FMT_RJ20: begin word_len = 5'd20; end
      `FMT_RJ24: begin word_len = 5'd24; end
      `FMT_I2S16: begin frame_kind = `FRAME_I2S; word_len = 5'd16; end
      `FMT_I2S20: begin frame_kind = `FRAME_I2S; word_len = 5'd20; end
      `FMT_I2S24: begin frame_kind = `FRAME_I2S; word_len = 5'd24; end
      `FMT_LJ16: begin frame_kind = `FRAME_LJ; word_len = 5'd16; end
      `FMT_DSP16: begin frame_kind = `FRAME_DSP; word_len = 5'd16; end
      default: begin fmt_reserved = 1'b1; end
    endcase
  end
  assign FMT_RESERVED_O = fmt_reserved;

  // ----------------------------------------
  // Control sequencer
  // ----------------------------------------
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] fmt_last;
  reg [13:0] init_cnt;
  reg sync_ready;
  wire fmt_changed = (fmt_code != fmt_last);
  always @* begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (sync_ready && pdn_ok) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (!pdn_ok || fmt_changed) begin
          next_state = ST_RESET;
        end else if (init_cnt == INIT_CYCLES[13:0] - 14'd1) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pdn_ok || fmt_changed) begin
          next_state = ST_RESET;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= ST_RESET;
      fmt_last <= 3'h0;
      init_cnt <= 14'h0;
      sync_ready <= 1'b0;
    end else begin
      state <= next_state;
      fmt_last <= fmt_code;
      // Lets the synchronisers fill before the format is trusted
      sync_ready <= 1'b1;
      if (state == ST_INIT) begin
        init_cnt <= init_cnt + 14'd1;
      end else begin
        init_cnt <= 14'h0;
      end
    end
  end
  wire running = (state == ST_RUN) && !fmt_reserved;

  // ----------------------------------------
  // Master clock generation
  // ----------------------------------------
  // mclk out only in master mode
  assign MCLK_OUT_O = MASTER_SEL_I ? CLK_I : 1'b0;
  // crystal output idle; clock arrives as system clock
  assign CRYSTAL_OUT_O = 1'b0;
  assign BIT_CLK_OE_O = MASTER_SEL_I;
  assign FRAME_CLK_OE_O = MASTER_SEL_I;
  reg [1:0] mdiv;
  reg [5:0] mbit;
  reg m_bclk_fall;
  // 64 Fs bit clock, Fs frame clock
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mdiv <= 2'h0;
      mbit <= 6'h0;
      BIT_CLK_O <= 1'b0;
      FRAME_CLK_O <= 1'b0;
      m_bclk_fall <= 1'b0;
    end else begin
      m_bclk_fall <= 1'b0;
      mdiv <= mdiv + 2'd1;
      if (mdiv == `BCLK_HALF_DIV) begin
        BIT_CLK_O <= 1'b1;
      end else if (mdiv == 2'd3) begin
        BIT_CLK_O <= 1'b0;
        m_bclk_fall <= 1'b1;
        mbit <= mbit + 6'd1;
        FRAME_CLK_O <= (mbit >= `HALF_FRAME) && (mbit != `BITS_PER_FRAME);
      end
    end
  end

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  reg bclk_prev;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bclk_prev <= 1'b0;
    end else begin
      bclk_prev <= pin_q[0];
    end
  end
  wire s_rise = pin_q[0] && !bclk_prev;
  wire bit_rise = MASTER_SEL_I ? (mdiv == `BCLK_HALF_DIV) : s_rise;
  wire lr_now = MASTER_SEL_I ? FRAME_CLK_O : pin_q[1];
  wire data_bit = pin_q[2];
  reg lr_prev;
  reg [5:0] bit_idx;
  reg [5:0] slot_len;
  reg [23:0] shreg;
  reg [23:0] left_word;
  reg [47:0] pair_word;
  reg pair_valid;
  wire fifo_ready;
  // DSP framing: short pulse at frame start, then left and right back to back
  wire lr_edge = (lr_now != lr_prev);
  wire dsp_start = (frame_kind == `FRAME_DSP) && lr_now && !lr_prev;
  wire [5:0] first_bit = (frame_kind == `FRAME_I2S) ? 6'd1 :
                         (frame_kind == `FRAME_RJ) ? (slot_len - {1'b0, word_len}) : 6'd0;
  wire in_word = (bit_idx >= first_bit) && (bit_idx < first_bit + {1'b0, word_len});
  wire word_done = in_word && (bit_idx == first_bit + {1'b0, word_len} - 6'd1);
  // In DSP framing the word index runs 0..31 over both channels
  wire dsp_right = (frame_kind == `FRAME_DSP) && (bit_idx >= {1'b0, word_len});
  wire [5:0] dsp_idx = dsp_right ? bit_idx - {1'b0, word_len} : bit_idx;
  wire dsp_in = dsp_idx < {1'b0, word_len};
  wire dsp_done = dsp_in && (dsp_idx == {1'b0, word_len} - 6'd1);
  wire take = (frame_kind == `FRAME_DSP) ? dsp_in : in_word;
  wire done = (frame_kind == `FRAME_DSP) ? dsp_done : word_done;
  wire is_left = (frame_kind == `FRAME_DSP) ? !dsp_right :
                 ((frame_kind == `FRAME_I2S) ? !lr_now : lr_now);
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lr_prev <= 1'b0;
      bit_idx <= 6'h0;
      slot_len <= 6'd32;
      shreg <= 24'h0;
      left_word <= 24'h0;
      pair_word <= 48'h0;
      pair_valid <= 1'b0;
    end else begin
      if (pair_valid && fifo_ready) begin
        pair_valid <= 1'b0;
      end
      if (bit_rise) begin
        lr_prev <= lr_now;
        // slot length follows the frame clock, for slots of up to 63 bit clocks
        if ((frame_kind == `FRAME_DSP) ? dsp_start : lr_edge) begin
          bit_idx <= 6'd1;
          slot_len <= bit_idx;
          shreg <= {23'h0, data_bit};
        end else begin
          bit_idx <= bit_idx + 6'd1;
          if (take) begin
            shreg <= {shreg[22:0], data_bit};
          end
          if (done && is_left) begin
            left_word <= ({shreg[22:0], data_bit}) << (5'd24 - word_len);
          end else if (done && running) begin
            // samples only enter when channel is live
            pair_word <= {left_word, ({shreg[22:0], data_bit}) << (5'd24 - word_len)};
            pair_valid <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Sample buffer
  // ----------------------------------------
  wire [47:0] fifo_data;
  wire fifo_valid;
  reg [`PWM_BITS-1:0] phase;
  wire fifo_take = (phase == {`PWM_BITS{1'b1}});
  sample_fifo #(
    .WIDTH(48),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .clear_i(!running),
    .in_data_i(pair_word),
    .in_valid_i(pair_valid),
    .in_ready_o(fifo_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take)
  );

  // ----------------------------------------
  // Modulator control
  // ----------------------------------------
  // de-emphasis only at normal speed with a 44.1/48 clock
  assign DEEMPH_ACTIVE_O = running && DEEMPH_ENABLE_I && !DOUBLE_SPEED_SEL_I;
  // curve select, meaningful only when active
  assign DEEMPH_48K_O = DEEMPH_ACTIVE_O && DEEMPH_RATE_SEL_I;
  reg [`PWM_BITS-1:0] duty_l;
  reg [`PWM_BITS-1:0] duty_r;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      phase <= {`PWM_BITS{1'b0}};
      duty_l <= 8'h80;
      duty_r <= 8'h80;
      VALID_L_O <= 1'b0;
      VALID_R_O <= 1'b0;
    end else begin
      phase <= phase + 8'd1;
      VALID_L_O <= running;
      VALID_R_O <= running;
      if (fifo_take) begin
        // mute low gives 50% duty silence, even with no new sample
        if (!MUTE_N_I) begin
          duty_l <= 8'h80;
          duty_r <= 8'h80;
        end else if (fifo_valid) begin
          duty_l <= {~fifo_data[47], fifo_data[46:40]};
          duty_r <= {~fifo_data[23], fifo_data[22:16]};
        end
      end
    end
  end

  // ----------------------------------------
  // PWM outputs
  // ----------------------------------------
  // two pairs per channel, hard-muted in reset
  pwm_pair u_left (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .run_i(running),
    .phase_i(phase),
    .duty_i(duty_l),
    .a_plus_o(LEFT_PAIR_A_PLUS_O),
    .a_minus_o(LEFT_PAIR_A_MINUS_O),
    .b_plus_o(LEFT_PAIR_B_PLUS_O),
    .b_minus_o(LEFT_PAIR_B_MINUS_O)
  );
  pwm_pair u_right (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .run_i(running),
    .phase_i(phase),
    .duty_i(duty_r),
    .a_plus_o(RIGHT_PAIR_A_PLUS_O),
    .a_minus_o(RIGHT_PAIR_A_MINUS_O),
    .b_plus_o(RIGHT_PAIR_B_PLUS_O),
    .b_minus_o(RIGHT_PAIR_B_MINUS_O)
  );
endmodule // pcm_pwm_ctl

// ==== pcm_pwm_ctl_assertions.sv ====
// Concurrent checks on the ports of the PCM input and PWM control block
`timescale 1ns/1ps
module pcm_pwm_ctl_assertions #(
  parameter INIT_CYCLES = 8
) (
  input wire CLK_I,
  input wire RST_I,
  input wire MASTER_SEL_I,
  input wire DOUBLE_SPEED_SEL_I,
  input wire DEEMPH_ENABLE_I,
  input wire DEEMPH_RATE_SEL_I,
  input wire POWER_DOWN_N_I,
  input wire FMT_SEL_0_I,
  input wire FMT_SEL_1_I,
  input wire FMT_SEL_2_I,
  input wire CRYSTAL_OUT_O,
  input wire BIT_CLK_O,
  input wire BIT_CLK_OE_O,
  input wire FRAME_CLK_O,
  input wire FRAME_CLK_OE_O,
  input wire MCLK_OUT_O,
  input wire DEEMPH_ACTIVE_O,
  input wire DEEMPH_48K_O,
  input wire FMT_RESERVED_O,
  input wire LEFT_PAIR_A_PLUS_O,
  input wire LEFT_PAIR_A_MINUS_O,
  input wire LEFT_PAIR_B_PLUS_O,
  input wire LEFT_PAIR_B_MINUS_O,
  input wire RIGHT_PAIR_A_PLUS_O,
  input wire RIGHT_PAIR_A_MINUS_O,
  input wire RIGHT_PAIR_B_PLUS_O,
  input wire RIGHT_PAIR_B_MINUS_O,
  input wire VALID_L_O,
  input wire VALID_R_O
);
  // Sync fill plus init plus slack for the valid flags
  localparam int INIT_MAX = INIT_CYCLES + 24;
  wire [2:0] fmt = {FMT_SEL_2_I, FMT_SEL_1_I, FMT_SEL_0_I};
  wire plus_any = LEFT_PAIR_A_PLUS_O | LEFT_PAIR_B_PLUS_O | RIGHT_PAIR_A_PLUS_O | RIGHT_PAIR_B_PLUS_O;
  wire minus_all = LEFT_PAIR_A_MINUS_O & LEFT_PAIR_B_MINUS_O & RIGHT_PAIR_A_MINUS_O & RIGHT_PAIR_B_MINUS_O;
  wire muted = !plus_any && minus_all && !VALID_L_O && !VALID_R_O;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  mclk_slave_low_a: assert property (!MASTER_SEL_I |-> !MCLK_OUT_O)
    else $error("master clock out not low in slave mode");
  pin_dir_a: assert property (BIT_CLK_OE_O == MASTER_SEL_I && FRAME_CLK_OE_O == MASTER_SEL_I)
    else $error("clock pin direction does not follow master select");
  reset_mute_a: assert property ($fell(RST_I) |-> muted [*8])
    else $error("outputs not hard muted after reset");
  init_valid_a: assert property ($fell(RST_I) && POWER_DOWN_N_I |-> ##[1:INIT_MAX] VALID_L_O)
    else $error("valid did not rise after reset release");
  fmt_restart_a: assert property ($changed(fmt) |-> ##[1:8] !VALID_L_O)
    else $error("format change did not restart");
  pdown_mute_a: assert property ($fell(POWER_DOWN_N_I) |-> ##[1:8] muted)
    else $error("power down did not hard mute");
  valid_pair_a: assert property (VALID_L_O == VALID_R_O)
    else $error("channel valid flags differ");
  deemph_on_a: assert property (DEEMPH_ACTIVE_O |-> DEEMPH_ENABLE_I && !DOUBLE_SPEED_SEL_I)
    else $error("de-emphasis active wrong");
  // Active is gated by the live state, seen one cycle later on valid
  deemph_run_a: assert property (DEEMPH_ENABLE_I && !DOUBLE_SPEED_SEL_I && !DEEMPH_ACTIVE_O
    |-> ##1 !VALID_L_O)
    else $error("de-emphasis off while running");
  pair_live_a: assert property (VALID_L_O |->
    (LEFT_PAIR_A_MINUS_O != LEFT_PAIR_A_PLUS_O) && (LEFT_PAIR_B_MINUS_O != LEFT_PAIR_B_PLUS_O)
    && (RIGHT_PAIR_A_MINUS_O != RIGHT_PAIR_A_PLUS_O)
    && (RIGHT_PAIR_B_MINUS_O != RIGHT_PAIR_B_PLUS_O))
    else $error("pair halves not complementary while valid");
  pair_mute_a: assert property (!VALID_L_O |-> !plus_any && minus_all)
    else $error("outputs not hard muted while not valid");
  deemph_rate_a: assert property (DEEMPH_48K_O == (DEEMPH_ACTIVE_O && DEEMPH_RATE_SEL_I))
    else $error("de-emphasis curve select wrong");
  fmt_known_a: assert property (!FMT_RESERVED_O)
    else $error("format code flagged reserved");
  xtal_idle_a: assert property (!CRYSTAL_OUT_O)
    else $error("crystal output not idle");
  bclk_div_a: assert property (MASTER_SEL_I && $rose(BIT_CLK_O) |-> ##2 $fell(BIT_CLK_O) ##2 $rose(BIT_CLK_O))
    else $error("bit clock period wrong");
  frame_div_a: assert property (MASTER_SEL_I && $rose(FRAME_CLK_O) |-> ##256 $rose(FRAME_CLK_O))
    else $error("frame clock period wrong");
endmodule // pcm_pwm_ctl_assertions

// ==== pcm_source_model.sv ====
// Serial PCM source standing in for the decoder in slave mode
`timescale 1ns/1ps
module pcm_source_model (
  output logic bclk_o,
  output logic lrclk_o,
  output logic data_o
);
  initial begin
    bclk_o = 1'b0;
    lrclk_o = 1'b1;
    data_o = 1'b0;
  end
  // 64 bit clocks a frame, 16-bit words one bit after the edge
  // Bit clock stands still between frames, as a real source may do
  task automatic send(input logic [15:0] left, input logic [15:0] right);
    logic [31:0] word;
    word = {left, right};
    for (int s = 0; s < 64; s++) begin
      if (s % 32 == 0) lrclk_o = (s == 32);
      if (s % 32 >= 1 && s % 32 <= 16) data_o = word[31 - 16 * (s / 32) - (s % 32 - 1)];
      else data_o = ~data_o;
      #62.5 bclk_o = 1'b1;
      #62.5 bclk_o = 1'b0;
    end
  endtask
endmodule // pcm_source_model

// ==== pcm_pwm_ctl_tb_top.sv ====
// Self-checking bench for the PCM input and PWM control block
`timescale 1ns/1ps
module pcm_pwm_ctl_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ms = 1'b0, dbl = 1'b0, den = 1'b0, dsel = 1'b0, mute_n = 1'b1, pdn_n = 1'b1;
  logic [2:0] fmt = 3'h3;
  logic pb, pf;
  wire bclk_o, bclk_oe, lr_o, lr_oe, mclk, dact, d48, fres, xout, vl, vr;
  wire src_bclk, src_lr, src_data;
  wire [7:0] pw;
  wire bclk_pin = bclk_oe ? bclk_o : src_bclk;
  wire lr_pin = lr_oe ? lr_o : src_lr;
  int n_mismatch = 0, compares = 0, seed = 55360;
  int cl, cr, cb, cf, clb, crb;
  int exp_q[$];
  always #5 clk = ~clk;
  pcm_pwm_ctl #(.INIT_CYCLES(8)) uut (
    .CLK_I(clk), .RST_I(rst), .MASTER_SEL_I(ms), .DOUBLE_SPEED_SEL_I(dbl),
    .DEEMPH_ENABLE_I(den), .DEEMPH_RATE_SEL_I(dsel), .MUTE_N_I(mute_n),
    .POWER_DOWN_N_I(pdn_n), .FMT_SEL_0_I(fmt[0]), .FMT_SEL_1_I(fmt[1]), .FMT_SEL_2_I(fmt[2]),
    .FACTORY_TEST_A_I(1'b0), .FACTORY_TEST_B_I(1'b0), .CRYSTAL_IN_I(1'b0),
    .CRYSTAL_OUT_O(xout), .BIT_CLK_I(bclk_pin), .BIT_CLK_O(bclk_o), .BIT_CLK_OE_O(bclk_oe),
    .FRAME_CLK_I(lr_pin), .FRAME_CLK_O(lr_o), .FRAME_CLK_OE_O(lr_oe),
    .SERIAL_AUDIO_IN_I(src_data), .MCLK_OUT_O(mclk), .DEEMPH_ACTIVE_O(dact),
    .DEEMPH_48K_O(d48), .FMT_RESERVED_O(fres),
    .LEFT_PAIR_A_PLUS_O(pw[7]), .LEFT_PAIR_A_MINUS_O(pw[6]),
    .LEFT_PAIR_B_PLUS_O(pw[5]), .LEFT_PAIR_B_MINUS_O(pw[4]),
    .RIGHT_PAIR_A_PLUS_O(pw[3]), .RIGHT_PAIR_A_MINUS_O(pw[2]),
    .RIGHT_PAIR_B_PLUS_O(pw[1]), .RIGHT_PAIR_B_MINUS_O(pw[0]),
    .VALID_L_O(vl), .VALID_R_O(vr)
  );
  pcm_source_model src (.bclk_o(src_bclk), .lrclk_o(src_lr), .data_o(src_data));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input int exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic measure(input int n);
    cl = 0;
    cr = 0;
    cb = 0;
    cf = 0;
    clb = 0;
    crb = 0;
    // Fresh reference so exactly n intervals are seen
    @(negedge clk);
    pb = bclk_o;
    pf = lr_o;
    repeat (n) begin
      @(negedge clk);
      if (pw[7] === 1'b1) cl++;
      if (pw[3] === 1'b1) cr++;
      if (pw[5] === 1'b1) clb++;
      if (pw[1] === 1'b1) crb++;
      if (bclk_o === 1'b1 && pb === 1'b0) cb++;
      if (lr_o === 1'b1 && pf === 1'b0) cf++;
      pb = bclk_o;
      pf = lr_o;
    end
  endtask
  task automatic wait_valid;
    int k;
    k = 0;
    while (vl !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk("valid_l", 1, vl);
  endtask
  // Duty is the top byte of the sample in offset binary, over two carriers
  task automatic play(input logic [15:0] l, input logic [15:0] r);
    int el;
    int er;
    exp_q.push_back(2 * ((int'($signed(l)) >>> 8) + 128));
    exp_q.push_back(2 * ((int'($signed(r)) >>> 8) + 128));
    src.send(l, r);
    repeat (600) @(negedge clk);
    measure(512);
    el = exp_q.pop_front();
    er = exp_q.pop_front();
    chk("left_duty", el, cl);
    chk("right_duty", er, cr);
    chk("left_duty_b", el, clb);
    chk("right_duty_b", er, crb);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    chk("reset_valid", 0, {vl, vr});
    chk("reset_pwm", 8'h55, pw);
    @(posedge clk);
    rst <= 1'b0;
    wait_valid();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {dbl, den, dsel} <= i[2:0];
      @(negedge clk);
      chk("deemph_active", i[1] & ~i[2], dact);
      chk("deemph_48k", i[1] & ~i[2] & i[0], d48);
    end
    @(posedge clk);
    dbl <= 1'b0;
    chk("mclk_slave", 0, mclk);
    chk("crystal_out", 0, xout);
    play(16'h8000, 16'h7fff);
    repeat (3) play(16'($random(seed)), 16'($random(seed)));
    @(posedge clk);
    mute_n <= 1'b0;
    repeat (600) @(negedge clk);
    measure(512);
    chk("mute_left", 256, cl);
    chk("mute_right", 256, cr);
    chk("mute_left_b", 256, clb);
    chk("mute_right_b", 256, crb);
    @(posedge clk);
    mute_n <= 1'b1;
    for (int k = 4; k < 12; k++) begin
      @(posedge clk);
      fmt <= k[2:0];
      repeat (10) @(negedge clk);
      chk("valid_after_fmt", 0, vl);
      wait_valid();
      chk("fmt_reserved", 0, fres);
    end
    @(posedge clk);
    pdn_n <= 1'b0;
    repeat (10) @(negedge clk);
    chk("pdown_pwm", 8'h55, pw);
    chk("pdown_valid", 0, vl);
    @(posedge clk);
    pdn_n <= 1'b1;
    wait_valid();
    // Master select only changes under reset
    @(posedge clk);
    rst <= 1'b1;
    ms <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_valid();
    measure(512);
    chk("bclk_rises", 128, cb);
    chk("frame_rises", 2, cf);
    chk("pin_dir", 3, {bclk_oe, lr_oe});
    @(posedge clk);
    #1 chk("mclk_master", 1, mclk);
    complete_run();
  end
  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end
endmodule // pcm_pwm_ctl_tb_top
bind pcm_pwm_ctl pcm_pwm_ctl_assertions #(.INIT_CYCLES(INIT_CYCLES)) chk_i (
  .CLK_I(CLK_I), .RST_I(RST_I), .MASTER_SEL_I(MASTER_SEL_I),
  .DOUBLE_SPEED_SEL_I(DOUBLE_SPEED_SEL_I), .DEEMPH_ENABLE_I(DEEMPH_ENABLE_I),
  .DEEMPH_RATE_SEL_I(DEEMPH_RATE_SEL_I), .POWER_DOWN_N_I(POWER_DOWN_N_I),
  .FMT_SEL_0_I(FMT_SEL_0_I), .FMT_SEL_1_I(FMT_SEL_1_I), .FMT_SEL_2_I(FMT_SEL_2_I),
  .CRYSTAL_OUT_O(CRYSTAL_OUT_O), .BIT_CLK_O(BIT_CLK_O), .BIT_CLK_OE_O(BIT_CLK_OE_O),
  .FRAME_CLK_O(FRAME_CLK_O), .FRAME_CLK_OE_O(FRAME_CLK_OE_O), .MCLK_OUT_O(MCLK_OUT_O),
  .DEEMPH_ACTIVE_O(DEEMPH_ACTIVE_O), .DEEMPH_48K_O(DEEMPH_48K_O),
  .FMT_RESERVED_O(FMT_RESERVED_O),
  .LEFT_PAIR_A_PLUS_O(LEFT_PAIR_A_PLUS_O), .LEFT_PAIR_A_MINUS_O(LEFT_PAIR_A_MINUS_O),
  .LEFT_PAIR_B_PLUS_O(LEFT_PAIR_B_PLUS_O), .LEFT_PAIR_B_MINUS_O(LEFT_PAIR_B_MINUS_O),
  .RIGHT_PAIR_A_PLUS_O(RIGHT_PAIR_A_PLUS_O), .RIGHT_PAIR_A_MINUS_O(RIGHT_PAIR_A_MINUS_O),
  .RIGHT_PAIR_B_PLUS_O(RIGHT_PAIR_B_PLUS_O), .RIGHT_PAIR_B_MINUS_O(RIGHT_PAIR_B_MINUS_O),
  .VALID_L_O(VALID_L_O), .VALID_R_O(VALID_R_O)
);
